// ---- verilog/cwl_calib_word.v ----
// Calibration word store reached through the program/verify port.
// Assumes the serial command decoder presents one decoded command per
// valid cycle together with the current program counter.
`timescale 1ns/1ns
`include "cwl_defines.vh"

module cwl_calib_word #(
  parameter [`CWL_WORD_W-1:0] CAL_FACTORY = `CWL_FACTORY_RST
) (
  input  wire                   sys_clk,
  input  wire                   nrst,
  input  wire                   three_bit_por,
  input  wire                   cmd_valid,
  input  wire [1:0]             cmd_op,
  input  wire [`CWL_PC_W-1:0]   pc_addr,
  input  wire [`CWL_WORD_W-1:0] wr_data,
  output reg  [`CWL_WORD_W-1:0] rd_data,
  output reg                    rd_valid,
  output reg                    cmd_done,
  output reg                    cmd_hit,
  output reg  [6:0]             osc_trim,
  output reg  [2:0]             por_trim,
  output reg  [2:0]             brownout_trim,
  output reg  [6:0]             osc_level,
  output reg  [2:0]             por_level,
  output reg  [2:0]             bor_level,
  output reg                    bor_reserved,
  output reg                    layout_three_bit
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [`CWL_WORD_W-1:0] cell_reg;
  reg  [`CWL_WORD_W-1:0] cell_next;
  reg                    layout_reg;
  reg                    layout_next;
  reg                    strap_seen_reg;
  reg  [`CWL_WORD_W-1:0] rd_data_next;
  reg                    rd_valid_next;
  reg                    cmd_done_next;
  reg                    cmd_hit_next;
  wire [`CWL_WORD_W-1:0] impl_mask;
  wire [`CWL_WORD_W-1:0] word_view;
  wire                   addr_hit;
  wire [6:0]             osc_field;
  wire [2:0]             por_field;
  wire [2:0]             bor_field;
  wire [6:0]             osc_level_w;
  wire [2:0]             por_level_w;
  wire [2:0]             bor_level_w;
  wire                   bor_reserved_w;

  // ----------------------------------------------------------------
  // Layout and field views
  // ----------------------------------------------------------------
  assign impl_mask = layout_reg ? `CWL_MASK_POR3 : `CWL_MASK_POR2;
  // Unimplemented bits forced to zero in every view
  assign word_view = cell_reg & impl_mask;
  assign addr_hit  = (pc_addr == `CWL_CAL_ADDR);
  assign osc_field = word_view[`CWL_OSC_MSB:`CWL_OSC_LSB];
  assign por_field = layout_reg ?
                     word_view[`CWL_POR3_MSB:`CWL_POR_LSB] :
                     {1'b0, word_view[`CWL_POR2_MSB:`CWL_POR_LSB]};
  assign bor_field = word_view[`CWL_BOR_MSB:`CWL_BOR_LSB];

  // ----------------------------------------------------------------
  // Level decoder
  // ----------------------------------------------------------------
  cwl_trim_decode u_decode (
    .three_bit_por (layout_reg),
    .osc_trim      (osc_field),
    .por_trim      (por_field),
    .brownout_trim (bor_field),
    .osc_level     (osc_level_w),
    .por_level     (por_level_w),
    .bor_level     (bor_level_w),
    .bor_reserved  (bor_reserved_w)
  );

  // ----------------------------------------------------------------
  // Layout strap
  // ----------------------------------------------------------------
  // Taken once after reset, frozen until the next reset
  always @* begin
    layout_next = layout_reg;
    if (!strap_seen_reg)
      layout_next = three_bit_por;
  end

  // ----------------------------------------------------------------
  // Command handling
  // ----------------------------------------------------------------
  always @* begin
    cell_next     = cell_reg;
    rd_data_next  = rd_data;
    rd_valid_next = 1'b0;
    cmd_done_next = 1'b0;
    cmd_hit_next  = 1'b0;
    if (cmd_valid) begin
      cmd_done_next = 1'b1;
      cmd_hit_next  = addr_hit;
      case (cmd_op)
        `CWL_CMD_READ: begin
          if (addr_hit) begin
            rd_data_next  = word_view;
            rd_valid_next = 1'b1;
          end
        end
        `CWL_CMD_LOAD: begin
          if (addr_hit)
            cell_next = wr_data & impl_mask;
        end
        `CWL_CMD_ERASE: begin
          // Only an erase aimed at this address touches the word
          if (addr_hit)
            cell_next = `CWL_ERASED & impl_mask;
        end
        default: begin
          cmd_done_next = 1'b0;
          cmd_hit_next  = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Word cell
  // ----------------------------------------------------------------
  // Factory value reloaded on every reset, standing in for power-up
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cell_reg <= CAL_FACTORY;
    end else begin
      cell_reg <= cell_next;
    end
  end

  // ----------------------------------------------------------------
  // Layout capture
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      layout_reg     <= 1'b0;
      strap_seen_reg <= 1'b0;
    end else begin
      layout_reg     <= layout_next;
      strap_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command strobes
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      cmd_done <= 1'b0;
      cmd_hit  <= 1'b0;
    end else begin
      rd_valid <= rd_valid_next;
      cmd_done <= cmd_done_next;
      cmd_hit  <= cmd_hit_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Holds the last read hit until the next one
  always @(posedge sys_clk) begin
    if (!nrst) begin
      rd_data <= {`CWL_WORD_W{1'b0}};
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Raw trim fields
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      osc_trim      <= 7'h00;
      por_trim      <= 3'h0;
      brownout_trim <= 3'h0;
    end else begin
      osc_trim      <= osc_field;
      por_trim      <= por_field;
      brownout_trim <= bor_field;
    end
  end

  // ----------------------------------------------------------------
  // Decoded levels
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      osc_level    <= 7'h00;
      por_level    <= 3'h0;
      bor_level    <= 3'h0;
      bor_reserved <= 1'b0;
    end else begin
      osc_level    <= osc_level_w;
      por_level    <= por_level_w;
      bor_level    <= bor_level_w;
      bor_reserved <= bor_reserved_w;
    end
  end

  // ----------------------------------------------------------------
  // Layout flag
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      layout_three_bit <= 1'b0;
    end else begin
      layout_three_bit <= layout_reg;
    end
  end

endmodule // cwl_calib_word

// ---- verilog/cwl_defines.vh ----
// Constants for the calibration word block: address, fields, masks, codes.
// Assumes a 14-bit program counter and a 14-bit configuration word.
`ifndef CWL_DEFINES_VH
`define CWL_DEFINES_VH

// ----------------------------------------------------------------
// Address and widths
// ----------------------------------------------------------------
`define CWL_PC_W          14
`define CWL_WORD_W        14
`define CWL_CAL_ADDR      14'h2008

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CWL_OSC_MSB       12
`define CWL_OSC_LSB       6
`define CWL_POR3_MSB      5
`define CWL_POR2_MSB      4
`define CWL_POR_LSB       3
`define CWL_BOR_MSB       2
`define CWL_BOR_LSB       0

// ----------------------------------------------------------------
// Implemented-bit masks and values
// ----------------------------------------------------------------
`define CWL_MASK_POR2     14'h1fdf
`define CWL_MASK_POR3     14'h1fff
`define CWL_ERASED        14'h3fff
`define CWL_FACTORY_RST   14'h0024

// ----------------------------------------------------------------
// Command codes on the program/verify port
// ----------------------------------------------------------------
`define CWL_CMD_READ      2'h0
`define CWL_CMD_LOAD      2'h1
`define CWL_CMD_ERASE     2'h2
`define CWL_CMD_NONE      2'h3

`endif

// ---- verilog/cwl_trim_decode.v ----
// Trim code decoder: turns raw trim fields into ordinal levels.
// Assumes fields come from the masked calibration word; purely combinational.
`timescale 1ns/1ns
`include "cwl_defines.vh"

module cwl_trim_decode (
  input  wire       three_bit_por,
  input  wire [6:0] osc_trim,
  input  wire [2:0] por_trim,
  input  wire [2:0] brownout_trim,
  output reg  [6:0] osc_level,
  output reg  [2:0] por_level,
  output reg  [2:0] bor_level,
  output reg        bor_reserved
);

  // ----------------------------------------------------------------
  // Level decode
  // ----------------------------------------------------------------
  always @* begin
    // Signed to offset binary, slowest is level 0
    osc_level = {~osc_trim[6], osc_trim[5:0]};
    bor_reserved = 1'b0;
    if (three_bit_por) begin
      // Sign-magnitude about centre: 011 min, 000/100 centre, 111 max
      if (por_trim[2])
        por_level = 3'h3 + {1'b0, por_trim[1:0]};
      else
        por_level = 3'h3 - {1'b0, por_trim[1:0]};
      if (brownout_trim[2])
        bor_level = 3'h3 + {1'b0, brownout_trim[1:0]};
      else
        bor_level = 3'h3 - {1'b0, brownout_trim[1:0]};
    end else begin
      por_level = {1'b0, por_trim[1:0]};
      if (brownout_trim == 3'h0) begin
        bor_level    = 3'h0;
        bor_reserved = 1'b1;
      end else begin
        bor_level = brownout_trim - 3'h1;
      end
    end
  end

endmodule // cwl_trim_decode

// ---- bench/cwl_calib_asserts.sv ----
// Assertions on the calibration word ports.
// Assumes the layout strap stays steady between resets.
`timescale 1ns/1ns
// ----------------
// Checker
// ----------------
module cwl_calib_asserts (
  input logic        sys_clk,
  input logic        nrst,
  input logic        cmd_valid,
  input logic [1:0]  cmd_op,
  input logic [13:0] pc_addr,
  input logic [13:0] rd_data,
  input logic        rd_valid,
  input logic        cmd_done,
  input logic        cmd_hit,
  input logic [6:0]  osc_trim,
  input logic [2:0]  brownout_trim,
  input logic [6:0]  osc_level,
  input logic        layout_three_bit
);
  logic [2:0] up_reg;
  wire        go = cmd_valid && cmd_op != 2'h3;
  wire        ok = up_reg[2];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  always @(posedge sys_clk) up_reg <= nrst ? {up_reg[1:0], 1'b1} : 3'h0;
  sequence s_hit; go && pc_addr == 14'h2008; endsequence
  sequence s_miss; go && pc_addr != 14'h2008; endsequence
  sequence s_rd; s_hit ##0 cmd_op == 2'h0; endsequence
  chk_hit_ack: assert property (s_hit |=> cmd_done && cmd_hit)
    else $error("hit command not acknowledged");
  chk_miss_no_hit: assert property (s_miss |=> cmd_done && !cmd_hit)
    else $error("miss command flagged as hit");
  chk_none_quiet: assert property (!go |=> !cmd_done && !rd_valid)
    else $error("idle cycle answered");
  chk_read_pulse: assert property (s_rd |=> rd_valid)
    else $error("read hit gave no data");
  chk_bit13_zero: assert property (rd_valid |-> !rd_data[13])
    else $error("bit 13 read as one");
  chk_bit5_zero: assert property (ok && !layout_three_bit
    |-> !(rd_valid && rd_data[5])) else $error("bit 5 read as one");
  chk_osc_field: assert property (rd_valid && ok
    |-> osc_trim == rd_data[12:6]) else $error("osc field misplaced");
  chk_osc_sign: assert property (ok
    |-> osc_level == {~osc_trim[6], osc_trim[5:0]})
    else $error("osc level order wrong");
  chk_miss_keeps: assert property (ok ##0 s_miss ##1 !go
    |=> $stable(osc_trim) && $stable(brownout_trim))
    else $error("word changed by miss");
endmodule // cwl_calib_asserts

bind cwl_calib_word cwl_calib_asserts u_chk (.*);

// ---- bench/cwl_prog_model.sv ----
// Programmer model: issue sends one command per call on the verify port; keep_cal sends five.
// Assumes the answer stands in the cycle after the taking edge.
`timescale 1ns/1ns
// ----------------
// Programmer
// ----------------
module cwl_prog_model (
  input  logic        sys_clk,
  input  logic [13:0] rd_data,
  input  logic        cmd_done,
  input  logic        cmd_hit,
  output logic        cmd_valid = 1'b0,
  output logic [1:0]  cmd_op = 2'h3,
  output logic [13:0] pc_addr = 14'h0,
  output logic [13:0] wr_data = 14'h0
);
  logic [13:0] got_data;
  logic        got_done;
  logic        got_hit;
  task automatic issue(input logic [1:0] op, input logic [13:0] pc, d);
    @(posedge sys_clk);
    {cmd_valid, cmd_op, pc_addr, wr_data} <= {1'b1, op, pc, d};
    @(posedge sys_clk);
    {cmd_valid, pc_addr, wr_data} <= {1'b0, ~pc, ~d};
    #1;
    {got_done, got_hit, got_data} = {cmd_done, cmd_hit, rd_data};
  endtask
  task automatic keep_cal(output logic [13:0] erased, output logic ok);
    logic [13:0] saved;
    issue(2'h0, 14'h2008, 14'h0);
    saved = got_data;
    issue(2'h2, 14'h2008, 14'h0);
    issue(2'h0, 14'h2008, 14'h0);
    erased = got_data;
    issue(2'h1, 14'h2008, saved);
    issue(2'h0, 14'h2008, 14'h0);
    ok = got_data === saved;
  endtask
endmodule // cwl_prog_model

// ---- bench/tb_top.sv ----
// Bench for the calibration word block in both trim layouts.
// Assumes a 50 MHz clock and the programmer model on the verify port.
`timescale 1ns/1ns
// ----------------
// Bench
// ----------------
module tb_top;
  localparam logic [13:0] CAL = 14'h2a6d;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        three_bit_por = 1'b0;
  logic        cmd_valid, cmd_done, cmd_hit, rd_valid, ok;
  logic        bor_reserved, layout_three_bit;
  logic [1:0]  cmd_op;
  logic [13:0] pc_addr, wr_data, rd_data, mask, erased;
  logic [6:0]  osc_trim, osc_level;
  logic [2:0]  por_trim, brownout_trim, por_level, bor_level;
  logic [13:0] cur, fexp;
  wire  [13:0] lvl = {osc_level, por_level, bor_level, bor_reserved};
  wire  [13:0] fld = {osc_trim, por_trim, brownout_trim, layout_three_bit};
  logic [13:0] ld [0:5] = '{14'h2fe0, 14'h1019, 14'h000f,
                            14'h2fdf, 14'h103b, 14'h0020};
  logic [13:0] ex [0:5] = '{14'h3f81, 14'h0030, 14'h201c,
                            14'h3f8c, 14'h0060, 14'h2036};
  int          err_count = 0;
  int          check_count = 0;
  cwl_calib_word #(.CAL_FACTORY(CAL)) u_dut (.*);
  cwl_prog_model u_prog (.*);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [13:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    for (int l = 0; l < 2; l++) begin
      @(posedge sys_clk);
      nrst <= 1'b0;
      three_bit_por <= l[0];
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      mask = l ? 14'h1fff : 14'h1fdf;
      u_prog.issue(2'h0, 14'h2008, 14'h0);
      chk(u_prog.got_data, CAL & mask);
      u_prog.issue(2'h3, 14'h2008, 14'h0);
      chk({13'h0, u_prog.got_done}, 14'h0);
      u_prog.issue(2'h2, 14'h2007, 14'h0);
      chk({13'h0, u_prog.got_hit}, 14'h0);
      u_prog.issue(2'h0, 14'h2008, 14'h0);
      chk(u_prog.got_data, CAL & mask);
      for (int i = 0; i < 3; i++) begin
        u_prog.issue(2'h1, 14'h2008, ld[l*3+i]);
        u_prog.issue(2'h0, 14'h2008, 14'h0);
        cur = ld[l*3+i] & mask;
        fexp = {cur[12:6], l ? cur[5:3] : {1'b0, cur[4:3]}, cur[2:0], l[0]};
        chk(u_prog.got_data, cur);
        chk(lvl, ex[l*3+i]);
        chk(fld, fexp);
      end
      u_prog.keep_cal(erased, ok);
      chk(erased, 14'h3fff & mask);
      chk({13'h0, ok}, 14'h1);
    end
    stop_test();
  end
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule // tb_top
